// File: core/pcs_consts.vh
// Offsets, field positions and reset values of the bus-control and bus-status words.
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

`define PCS_CTL_OFS         8'h04
`define PCS_STS_OFS         8'h06
`define PCS_CTL_RST         16'h0000
`define PCS_STS_RST         16'h0290

`define PCS_CTL_PORT_SPACE  0
`define PCS_CTL_MEM_DECODE  1
`define PCS_CTL_INITIATOR   2
`define PCS_CTL_SPECIAL     3
`define PCS_CTL_WR_INVAL    4
`define PCS_CTL_PALETTE     5
`define PCS_CTL_PAR_RESP    6
`define PCS_CTL_STEPPING    7
`define PCS_CTL_SYSTEM_FAULT_SIGNALLED_EN  8
`define PCS_CTL_B2B_ISSUE   9

`define PCS_CTL_RW_MASK     16'h0156

`define PCS_STS_CAP_LIST    4
`define PCS_STS_DBL_SPEED   5
`define PCS_STS_B2B_ACCEPT  7
`define PCS_STS_INIT_DPAR   8
`define PCS_STS_DECODE_LO   9
`define PCS_STS_DECODE_HI   10
`define PCS_STS_TARGET_ABORT_SIGNALLED  11
`define PCS_STS_TABORT_RCV  12
`define PCS_STS_INIT_ABORT  13
`define PCS_STS_SYS_FAULT   14
`define PCS_STS_PAR_FAULT   15

`define PCS_STS_FIXED_MASK  16'h0690
`define PCS_DECODE_MEDIUM   2'h1
`define PCS_EVT_W           6

`endif

// File: core/pcs_reset_sync.v
// Two-stage release synchroniser for the asynchronous active-low reset.
`default_nettype none

module pcs_reset_sync (
    input  wire clk,
    input  wire arst_n,
    output wire srst_n
);

    reg stage1_q;
    reg stage2_q;

    // Assertion is immediate; release is seen two edges later, clean of the clock.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign srst_n = stage2_q;

endmodule // pcs_reset_sync

`default_nettype wire

// File: core/pcs_sticky_bank.v
// Bank of sticky event flags, set by hardware and cleared by writing one.
`default_nettype none

module pcs_sticky_bank #(
    parameter W = 6
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] set,
    input  wire [W-1:0] clr,
    output wire [W-1:0] flags
);

    reg [W-1:0] flags_q;
    wire [W-1:0] flags_d;

    // A set in the same cycle as a clear wins, so no event is ever lost.
    assign flags_d = (flags_q & ~clr) | set;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= {W{1'b0}};
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule // pcs_sticky_bank

`default_nettype wire

// File: core/pcs_cmd_status.v
// Bus-control and bus-status configuration words with the gating they apply.
`include "pcs_consts.vh"
`default_nettype none

module pcs_cmd_status (
    input  wire        core_clk,
    input  wire        nrst,
    input  wire        cfg_rd,
    input  wire        cfg_wr,
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output wire [31:0] cfg_rdata,
    output wire        cfg_ack,
    input  wire        addr_parity_err,
    input  wire        data_parity_err,
    input  wire        init_data_parity_err,
    input  wire        init_xfer_done,
    input  wire        init_special_cycle,
    input  wire        init_master_abort,
    input  wire        init_target_abort,
    input  wire        tgt_target_abort,
    input  wire        mem_cycle_hit,
    input  wire        port_cycle_hit,
    input  wire        special_cycle_hit,
    input  wire        init_req,
    input  wire        init_req_write,
    output wire        mem_claim,
    output wire        port_claim,
    output wire        special_claim,
    output wire        init_start,
    output wire        init_use_wr_inval,
    output wire        system_error_out_n,
    output wire        system_error_oe,
    output wire        parity_error_out_n,
    output wire        parity_error_oe,
    output wire        system_error_drive_enable,
    output wire        parity_response_enable,
    output wire        write_invalidate_enable,
    output wire        initiator_enable,
    output wire        memory_decode_enable
);

    localparam EVT_PAR  = 5;
    localparam EVT_SYS  = 4;
    localparam EVT_MAB  = 3;
    localparam EVT_TRCV = 2;
    localparam EVT_TSIG = 1;
    localparam EVT_DPAR = 0;

    wire rst_n;

    pcs_reset_sync u_rst (
        .clk    (core_clk),
        .arst_n (nrst),
        .srst_n (rst_n)
    );

    // Configuration word decode; the two words share one aligned dword.
    function hit_dword;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit_dword = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    wire ctl_hit;
    wire sts_hit;
    wire ctl_wr_lo;
    wire ctl_wr_hi;
    wire sts_wr_lo;
    wire sts_wr_hi;

    assign ctl_hit   = hit_dword(cfg_addr, `PCS_CTL_OFS);
    assign sts_hit   = hit_dword(cfg_addr, `PCS_STS_OFS);
    assign ctl_wr_lo = cfg_wr & ctl_hit & cfg_be[0];
    assign ctl_wr_hi = cfg_wr & ctl_hit & cfg_be[1];
    assign sts_wr_lo = cfg_wr & sts_hit & cfg_be[2];
    assign sts_wr_hi = cfg_wr & sts_hit & cfg_be[3];

    // Bus-control word: only the writable bits are stored at all.
    reg  [15:0] ctl_q;
    reg  [15:0] ctl_d;
    wire [15:0] ctl_wdata;

    assign ctl_wdata = cfg_wdata[15:0] & `PCS_CTL_RW_MASK;

    always @* begin
        ctl_d = ctl_q;
        if (ctl_wr_lo) begin
            ctl_d[7:0] = ctl_wdata[7:0];
        end
        if (ctl_wr_hi) begin
            ctl_d[15:8] = ctl_wdata[15:8];
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= `PCS_CTL_RST;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    wire serr_en;
    wire perr_en;
    wire mwi_en;
    wire mst_en;
    wire mem_en;

    assign serr_en = ctl_q[`PCS_CTL_SYSTEM_FAULT_SIGNALLED_EN];
    assign perr_en = ctl_q[`PCS_CTL_PAR_RESP];
    assign mwi_en  = ctl_q[`PCS_CTL_WR_INVAL];
    assign mst_en  = ctl_q[`PCS_CTL_INITIATOR];
    assign mem_en  = ctl_q[`PCS_CTL_MEM_DECODE];

    // Pin drivers. Both pins are open drain: low while enabled, released otherwise.
    reg serr_oe_q;
    reg perr_oe_q;
    reg serr_out_n_q;
    reg perr_out_n_q;
    wire serr_fire;
    wire perr_fire;

    assign serr_fire = addr_parity_err & serr_en;
    assign perr_fire = data_parity_err & perr_en;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serr_oe_q    <= 1'b0;
            perr_oe_q    <= 1'b0;
            serr_out_n_q <= 1'b1;
            perr_out_n_q <= 1'b1;
        end else begin
            serr_oe_q    <= serr_fire;
            serr_out_n_q <= ~serr_fire;
            perr_oe_q    <= perr_fire;
            perr_out_n_q <= ~perr_fire;
        end
    end

    // Event capture. The system-error flag follows the pin drive itself so that
    // the flag and the pin can never disagree.
    wire [`PCS_EVT_W-1:0] evt_set;
    wire [`PCS_EVT_W-1:0] evt_clr;
    wire [`PCS_EVT_W-1:0] evt_q;

    assign evt_set[EVT_PAR]  = addr_parity_err | data_parity_err
                             | init_data_parity_err;
    assign evt_set[EVT_SYS]  = serr_fire;
    assign evt_set[EVT_MAB]  = init_xfer_done & init_master_abort
                             & ~init_special_cycle;
    assign evt_set[EVT_TRCV] = init_xfer_done & init_target_abort;
    assign evt_set[EVT_TSIG] = tgt_target_abort;
    // The initiator parity flag only counts while parity response is enabled.
    assign evt_set[EVT_DPAR] = init_data_parity_err & perr_en;

    assign evt_clr[EVT_PAR]  = sts_wr_hi & cfg_wdata[16 + `PCS_STS_PAR_FAULT];
    assign evt_clr[EVT_SYS]  = sts_wr_hi & cfg_wdata[16 + `PCS_STS_SYS_FAULT];
    assign evt_clr[EVT_MAB]  = sts_wr_hi & cfg_wdata[16 + `PCS_STS_INIT_ABORT];
    assign evt_clr[EVT_TRCV] = sts_wr_hi & cfg_wdata[16 + `PCS_STS_TABORT_RCV];
    assign evt_clr[EVT_TSIG] = sts_wr_hi & cfg_wdata[16 + `PCS_STS_TARGET_ABORT_SIGNALLED];
    assign evt_clr[EVT_DPAR] = sts_wr_hi & cfg_wdata[16 + `PCS_STS_INIT_DPAR];

    pcs_sticky_bank #(
        .W (`PCS_EVT_W)
    ) u_evt (
        .clk   (core_clk),
        .rst_n (rst_n),
        .set   (evt_set),
        .clr   (evt_clr),
        .flags (evt_q)
    );

    // Bus-status word assembled from fixed capability bits and live flags.
    // The low status byte holds nothing writable, so sts_wr_lo has no effect.
    wire [15:0] sts_val;
    wire [15:0] sts_fixed;

    assign sts_fixed = `PCS_STS_RST & `PCS_STS_FIXED_MASK;

    assign sts_val = {evt_q[EVT_PAR],
                      evt_q[EVT_SYS],
                      evt_q[EVT_MAB],
                      evt_q[EVT_TRCV],
                      evt_q[EVT_TSIG],
                      sts_fixed[`PCS_STS_DECODE_HI:`PCS_STS_DECODE_LO],
                      evt_q[EVT_DPAR],
                      sts_fixed[7:0]};

    wire unused_lo;
    assign unused_lo = sts_wr_lo;

    // Read path; every access is answered one cycle later, unmapped ones with zero.
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         ack_q;

    always @* begin
        rdata_d = 32'h0000_0000;
        if (cfg_rd && ctl_hit) begin
            rdata_d = {sts_val, ctl_q};
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ack_q   <= cfg_rd | cfg_wr;
        end
    end

    // Bus-side gating, registered so every output leaves a flip-flop.
    reg mem_claim_q;
    reg port_claim_q;
    reg special_claim_q;
    reg init_start_q;
    reg init_mwi_q;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_claim_q     <= 1'b0;
            port_claim_q    <= 1'b0;
            special_claim_q <= 1'b0;
            init_start_q    <= 1'b0;
            init_mwi_q      <= 1'b0;
        end else begin
            mem_claim_q     <= mem_cycle_hit & mem_en;
            port_claim_q    <= port_cycle_hit & ctl_q[`PCS_CTL_PORT_SPACE];
            special_claim_q <= special_cycle_hit & ctl_q[`PCS_CTL_SPECIAL];
            init_start_q    <= init_req & mst_en;
            init_mwi_q      <= init_req & mst_en & init_req_write & mwi_en;
        end
    end

    // Enable levels handed to the rest of the bus interface.
    reg [4:0] en_q;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 5'h00;
        end else begin
            en_q <= {serr_en, perr_en, mwi_en, mst_en, mem_en};
        end
    end

    assign cfg_rdata                 = rdata_q;
    assign cfg_ack                   = ack_q;
    assign mem_claim                 = mem_claim_q;
    assign port_claim                = port_claim_q;
    assign special_claim             = special_claim_q;
    assign init_start                = init_start_q;
    assign init_use_wr_inval         = init_mwi_q;
    assign system_error_out_n        = serr_out_n_q;
    assign system_error_oe           = serr_oe_q;
    assign parity_error_out_n        = perr_out_n_q;
    assign parity_error_oe           = perr_oe_q;
    assign system_error_drive_enable = en_q[4];
    assign parity_response_enable    = en_q[3];
    assign write_invalidate_enable   = en_q[2];
    assign initiator_enable          = en_q[1];
    assign memory_decode_enable      = en_q[0];

endmodule // pcs_cmd_status

`default_nettype wire

// File: testbench/pcs_cmd_status_checker.sv
// Port-level checks on the bus-control and bus-status words.
`default_nettype none
module pcs_cmd_status_checker (
    input wire logic        core_clk, nrst, cfg_rd, cfg_wr, cfg_ack,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_rdata,
    input wire logic        addr_parity_err, data_parity_err, mem_cycle_hit,
    input wire logic        init_req, init_req_write, mem_claim, port_claim,
    input wire logic        special_claim, init_start, init_use_wr_inval,
    input wire logic        system_error_oe, system_error_out_n, parity_error_oe,
    input wire logic        parity_error_out_n,
    input wire logic        system_error_drive_enable, parity_response_enable,
    input wire logic        write_invalidate_enable, initiator_enable,
    input wire logic        memory_decode_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_rd_word;
        cfg_rd && cfg_addr[7:2] == 6'h01;
    endsequence
    chk_ctl_fixed_zero: assert property (s_rd_word |=> cfg_rdata[15:9] == 7'h00
        && cfg_rdata[7] == 1'b0 && cfg_rdata[5] == 1'b0 && cfg_rdata[3] == 1'b0
        && cfg_rdata[0] == 1'b0) else $error("control fixed bits wrong");
    chk_sts_fixed_bits: assert property (s_rd_word |=> cfg_rdata[26:25] == 2'h1
        && cfg_rdata[23:16] == 8'h90) else $error("status fixed bits wrong");
    chk_no_side_claims: assert property (!port_claim && !special_claim)
        else $error("port or special claim");
    chk_mem_claim_gate: assert property (mem_claim == ($past(mem_cycle_hit) && memory_decode_enable))
        else $error("memory claim gating");
    chk_init_start_gate: assert property (init_start == ($past(init_req) && initiator_enable))
        else $error("initiator start gating");
    chk_wr_inval_gate: assert property (init_use_wr_inval == ($past(init_req && init_req_write)
        && initiator_enable && write_invalidate_enable)) else $error("write-invalidate gating");
    chk_serr_pin_drive: assert property (system_error_oe == ($past(addr_parity_err)
        && system_error_drive_enable) && system_error_out_n == !system_error_oe)
        else $error("system error pin");
    chk_perr_pin_drive: assert property (parity_error_oe == ($past(data_parity_err)
        && parity_response_enable) && parity_error_out_n == !parity_error_oe)
        else $error("parity error pin");
    chk_serr_flag_set: assert property (system_error_oe ##1 s_rd_word |=> cfg_rdata[30])
        else $error("system fault flag not set");
    chk_par_flag_set: assert property (data_parity_err ##2 s_rd_word |=> cfg_rdata[31])
        else $error("parity fault flag not set");
endmodule // pcs_cmd_status_checker
bind pcs_cmd_status pcs_cmd_status_checker u_pcs_chk (
    .core_clk, .nrst, .cfg_rd, .cfg_wr, .cfg_ack, .cfg_addr, .cfg_rdata, .addr_parity_err,
    .data_parity_err, .mem_cycle_hit, .init_req, .init_req_write, .mem_claim, .port_claim,
    .special_claim, .init_start, .init_use_wr_inval, .system_error_oe, .system_error_out_n,
    .parity_error_oe, .parity_error_out_n, .system_error_drive_enable, .parity_response_enable,
    .write_invalidate_enable, .initiator_enable, .memory_decode_enable
);
`default_nettype wire

// File: testbench/pcs_host_model.sv
// Host bridge model issuing configuration reads and writes.
`default_nettype none
module pcs_host_model (
    input  wire logic        clk,
    output var  logic        cfg_rd,
    output var  logic        cfg_wr,
    output var  logic [7:0]  cfg_addr,
    output var  logic [3:0]  cfg_be,
    output var  logic [31:0] cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
    end
    // Released address and data lines show the inverse so stale values cannot pass for live ones.
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #1;
        {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {~wr, wr, a, be, d};
        @(posedge clk);
        #1;
        {cfg_rd, cfg_wr, cfg_addr, cfg_wdata} = {2'h0, ~a, ~d};
        q = cfg_ack ? cfg_rdata : ~cfg_rdata;
    endtask
endmodule // pcs_host_model
`default_nettype wire

// File: testbench/pcs_cmd_status_tb_top.sv
// Self-checking bench for the bus-control and bus-status words.
`default_nettype none
module pcs_cmd_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] be; logic [31:0] wd; logic [12:0] ev; logic [31:0] exp;
    } pcs_row_t;
    logic        core_clk, nrst, cfg_rd, cfg_wr, cfg_ack;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, q;
    logic [12:0] ev;
    logic        mem_claim, port_claim, special_claim, init_start, init_use_wr_inval;
    logic        system_error_out_n, system_error_oe, parity_error_out_n, parity_error_oe;
    logic        system_error_drive_enable, parity_response_enable, write_invalidate_enable;
    logic        initiator_enable, memory_decode_enable;
    wire logic   mem_cycle_hit, port_cycle_hit, special_cycle_hit, init_req, init_req_write;
    wire logic   init_special_cycle, init_master_abort, init_target_abort, tgt_target_abort;
    wire logic   addr_parity_err, data_parity_err, init_data_parity_err, init_xfer_done;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;
    assign {mem_cycle_hit, port_cycle_hit, special_cycle_hit, init_req, init_req_write,
            tgt_target_abort, init_target_abort, init_master_abort, init_special_cycle,
            init_xfer_done, init_data_parity_err, data_parity_err, addr_parity_err} = ev;
    pcs_row_t rows [13] = '{
        '{4'hF, 32'hFFFF_FFFF, 13'h0000, 32'h0290_0156},
        '{4'h1, 32'h0, 13'h0000, 32'h0290_0100},
        '{4'h3, 32'h0000_0012, 13'h0000, 32'h0290_0012},
        '{4'h0, 32'hFFFF_FFFF, 13'h0001, 32'h8290_0012},
        '{4'h3, 32'h0, 13'h0002, 32'h8290_0000},
        '{4'h0, 32'h0, 13'h0004, 32'h8290_0000},
        '{4'h0, 32'h0, 13'h0038, 32'h0290_0000},
        '{4'h0, 32'h0, 13'h0028, 32'h2290_0000},
        '{4'h0, 32'h0, 13'h0048, 32'h1290_0000},
        '{4'h0, 32'h0, 13'h0080, 32'h0A90_0000},
        '{4'h3, 32'h0000_0140, 13'h0001, 32'hC290_0140},
        '{4'h0, 32'h0, 13'h0004, 32'h8390_0140},
        '{4'h0, 32'h0, 13'h0002, 32'h8290_0140}
    };
    pcs_cmd_status DUT (
        .core_clk, .nrst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
        .cfg_ack, .addr_parity_err, .data_parity_err, .init_data_parity_err, .init_xfer_done,
        .init_special_cycle, .init_master_abort, .init_target_abort, .tgt_target_abort,
        .mem_cycle_hit, .port_cycle_hit, .special_cycle_hit, .init_req, .init_req_write,
        .mem_claim, .port_claim, .special_claim, .init_start, .init_use_wr_inval,
        .system_error_out_n, .system_error_oe, .parity_error_out_n, .parity_error_oe,
        .system_error_drive_enable, .parity_response_enable, .write_invalidate_enable,
        .initiator_enable, .memory_decode_enable
    );
    pcs_host_model u_host (
        .clk(core_clk), .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack
    );
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fire(input logic [12:0] v);
        ev = v;
        @(posedge core_clk);
        #1;
        ev = 13'h0000;
    endtask
    task automatic summarize();
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        nrst = 1'b0;
        ev = 13'h0000;
        repeat (8) @(posedge core_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge core_clk);
        u_host.access(1'b0, 8'h04, 4'hF, 32'h0, q);
        chk(q, 32'h0290_0000);
        foreach (rows[i]) begin
            u_host.access(1'b1, 8'h04, rows[i].be, rows[i].wd, q);
            if (rows[i].ev !== 13'h0000) fire(rows[i].ev);
            u_host.access(1'b0, 8'h06, 4'hF, 32'h0, q);
            chk(q, rows[i].exp);
            u_host.access(1'b1, 8'h04, 4'h8, 32'hFFFF_0000, q);
        end
        for (int k = 0; k < 2; k++) begin
            u_host.access(1'b1, 8'h04, 4'h3, k ? 32'h0000_0156 : 32'h0, q);
            fire(13'h1F00);
            chk({27'h0, mem_claim, port_claim, special_claim, init_start,
                 init_use_wr_inval}, k ? 32'h0000_0013 : 32'h0);
            chk({27'h0, system_error_drive_enable, parity_response_enable,
                 write_invalidate_enable, initiator_enable, memory_decode_enable},
                k ? 32'h0000_001F : 32'h0);
        end
        u_host.access(1'b1, 8'h0C, 4'hF, 32'hFFFF_FFFF, q);
        u_host.access(1'b0, 8'h0C, 4'hF, 32'h0, q);
        chk(q, 32'h0);
        // A hardware set landing on the same edge as a clear must survive.
        fork
            u_host.access(1'b1, 8'h04, 4'h8, 32'hFFFF_0000, q);
            begin
                @(posedge core_clk);
                #1;
                fire(13'h0080);
            end
        join
        u_host.access(1'b0, 8'h04, 4'hF, 32'h0, q);
        chk(q, 32'h0A90_0156);
        nrst = 1'b0;
        @(posedge core_clk);
        chk({30'h0, system_error_out_n, parity_error_out_n}, 32'h3);
        #1 nrst = 1'b1;
        repeat (3) @(posedge core_clk);
        u_host.access(1'b0, 8'h04, 4'hF, 32'h0, q);
        chk(q, 32'h0290_0000);
        summarize();
    end
endmodule // pcs_cmd_status_tb_top
`default_nettype wire
